// ==== bench/spcs_bench.sv ====
// self-checking bench for spcs_top with two winding models
// assumes short pwm period parameters 400 and 8
`timescale 1ns/10ps
`default_nettype none
module spcs_bench;
  import spcs_pkg::*;
  localparam int PER = 400 + 8 * 20;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, lost = 0, fast = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, err, ahp, ahl, phase_a_minus_high_overcurrent, aml, bph, bpl, bmh, bml, ca, cb, boost;
  logic [5:0] dla, dlb;
  logic [10:0] ta, tb;
  int n_mismatch = 0, total_checks = 0, cyc = 0;
  spcs_top #(.PWM_BASE_CYCLES(400), .PWM_STEP_CYCLES(8)) DUT (
    .clk, .rst, .ce(1'h1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .comp_above_a(ca), .comp_above_b(cb), .gate_a_plus_high(ahp), .gate_a_plus_low(ahl),
    .gate_a_minus_high(phase_a_minus_high_overcurrent), .gate_a_minus_low(aml), .gate_b_plus_high(bph), .gate_b_plus_low(bpl),
    .gate_b_minus_high(bmh), .gate_b_minus_low(bml), .dac_level_a(dla), .dac_level_b(dlb),
    .phase_dir_neg_a(), .phase_dir_neg_b(), .current_target_a(ta), .current_target_b(tb),
    .low_side_ron_boost(boost));
  spcs_winding u_wa (.clk, .plus_high(ahp), .plus_low(ahl), .minus_high(phase_a_minus_high_overcurrent), .minus_low(aml),
    .target(ta), .sense_lost(lost), .comp(ca));
  spcs_winding u_wb (.clk, .plus_high(bph), .plus_low(bpl), .minus_high(bmh), .minus_low(bml),
    .target(tb), .sense_lost(1'h0), .comp(cb));
  initial forever #2.5 clk = ~clk;
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      tally_and_finish;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    // pready seen at the edge itself, before the design updates it
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) chk(32'h0000_0001, 32'h0000_0000);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic angle_is(input logic [5:0] e);
    apb(1'h0, ADDR_STATUS, 32'h0000_0000);
    chk({26'h0, rd[5:0]}, {26'h0, e});
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask
  // counts cycles until gate_a_plus_high shows level v, noting fast decay
  task automatic wait_lvl(input logic v, output int c);
    c = 0;
    do begin
      @(negedge clk);
      fast |= phase_a_minus_high_overcurrent;
      c++;
    end while (ahp !== v && c < 2 * PER);
  endtask
  task automatic t_reset;
    apb(1'h0, ADDR_CTRL, 32'h0000_0000);
    chk(rd, 32'h0000_0130);
    apb(1'h0, ADDR_CURRENT, 32'h0000_0000);
    chk(rd, 32'h0014_001F);
    angle_is(6'h08);
    chk({26'h0, dla}, 32'h0000_002D);
    chk({26'h0, dlb}, 32'h0000_002D);
    apb(1'h0, 8'h20, 32'h0000_0000);
    chk({rd[31:1], err}, 32'h0000_0001);
    $display("reset test done");
  endtask
  task automatic t_table;
    apb(1'h1, ADDR_STEP_DELTA, 32'h0000_0038);
    angle_is(6'h00);
    settle(4);
    chk({26'h0, dla}, 32'h0000_003F);
    chk({21'h0, ta}, 32'h0000_07A1);
    apb(1'h1, ADDR_STEP_DELTA, 32'h0000_003F);
    angle_is(6'h3F);
    apb(1'h1, ADDR_STEP_DELTA, 32'h0000_0001);
    angle_is(6'h00);
    $display("table test done");
  endtask
  task automatic t_ron;
    apb(1'h1, ADDR_CURRENT, 32'h0014_0003);
    settle(4);
    chk({31'h0, boost}, 32'h0000_0000);
    apb(1'h1, ADDR_CURRENT, 32'h0014_0001);
    settle(4);
    chk({31'h0, boost}, 32'h0000_0001);
    $display("ron test done");
  endtask
  task automatic t_pwm;
    int c, on, off;
    wait_lvl(1'h1, c);
    wait_lvl(1'h0, on);
    fast = 1'h0;
    wait_lvl(1'h1, off);
    chk(32'(on + off), 32'(PER));
    chk(32'(on >= BLANK_CYC - DEAD_CYC), 32'h0000_0001);
    chk({31'h0, fast}, 32'h0000_0001);
    $display("pwm test done");
  endtask
  task automatic t_limit;
    @(posedge clk);
    lost <= 1'h1;
    settle(3 * PER);
    apb(1'h0, ADDR_STATUS, 32'h0000_0000);
    chk({28'h0, rd[15:12]}, 32'h0000_0000);
    apb(1'h1, ADDR_CURRENT, 32'h0014_0101);
    settle(3 * PER);
    chk({28'h0, ahp, ahl, phase_a_minus_high_overcurrent, aml}, 32'h0000_0000);
    apb(1'h0, ADDR_STATUS, 32'h0000_0000);
    chk({28'h0, rd[15:12]}, 32'h0000_0001);
    lost <= 1'h0;
    apb(1'h1, ADDR_CURRENT, 32'h0014_0001);
    apb(1'h1, ADDR_STATUS, 32'h0000_F000);
    apb(1'h0, ADDR_STATUS, 32'h0000_0000);
    chk({28'h0, rd[15:12]}, 32'h0000_0000);
    $display("limit test done");
  endtask
  task automatic t_halt;
    apb(1'h1, ADDR_CTRL, 32'h0000_0162);
    apb(1'h1, ADDR_PROFILE, 32'h0000_0001);
    apb(1'h1, ADDR_COUNT_LOW, 32'h0000_0004);
    apb(1'h0, ADDR_STATUS, 32'h0000_0000);
    chk({31'h0, rd[8]}, 32'h0000_0000);
    settle(3 * PER);
    angle_is(6'h00);
    apb(1'h1, ADDR_CTRL, 32'h0000_0160);
    settle(8 * PER);
    angle_is(6'h04);
    apb(1'h1, ADDR_CTRL, 32'h0000_0150);
    apb(1'h1, ADDR_PROFILE, 32'h0000_0001);
    settle(3 * PER);
    angle_is(6'h04);
    apb(1'h1, ADDR_COUNT_LOW, 32'h0000_0002);
    settle(6 * PER);
    angle_is(6'h08);
    apb(1'h1, ADDR_PROFILE, 32'h0000_0000);
    apb(1'h1, ADDR_COUNT_LOW, 32'h0000_0001);
    settle(4 * PER);
    apb(1'h0, ADDR_STATUS, 32'h0000_0000);
    chk({31'h0, rd[9]}, 32'h0000_0001);
    apb(1'h1, ADDR_CTRL, 32'h0000_0151);
    settle(2 * PER);
    apb(1'h0, ADDR_STATUS, 32'h0000_0000);
    chk({31'h0, rd[9]}, 32'h0000_0000);
    $display("halt test done");
  endtask
  task automatic t_short;
    int c;
    wait_lvl(1'h1, c);
    wait_lvl(1'h0, c);
    apb(1'h1, ADDR_CTRL, 32'h0000_0154);
    settle(50);
    chk({24'h0, ahp, ahl, phase_a_minus_high_overcurrent, aml, bph, bpl, bmh, bml}, 32'h0000_0055);
    apb(1'h1, ADDR_CTRL, 32'h0000_0150);
    $display("short test done");
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    t_reset;
    t_table;
    t_ron;
    t_pwm;
    t_limit;
    t_halt;
    t_short;
    tally_and_finish;
  end
endmodule // spcs_bench
`default_nettype wire

// ==== bench/spcs_checker.sv ====
// port checker for spcs_top: gate lockout, blanking and apb timing
// assumes it is bound to spcs_top and sees only its ports
`timescale 1ns/10ps
`default_nettype none
module spcs_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic gate_a_plus_high,
  input wire logic gate_a_plus_low,
  input wire logic gate_a_minus_high,
  input wire logic gate_a_minus_low
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_lock_plus; !(gate_a_plus_high && gate_a_plus_low); endproperty
  a_lock_plus: assert property (p_lock_plus) else $error("plus leg both on");
  property p_lock_minus; !(gate_a_minus_high && gate_a_minus_low); endproperty
  a_lock_minus: assert property (p_lock_minus) else $error("minus leg both on");
  property p_dead_plus; $fell(gate_a_plus_low) |-> !gate_a_plus_high [*8]; endproperty
  a_dead_plus: assert property (p_dead_plus) else $error("plus leg no dead time");
  property p_dead_minus; $fell(gate_a_minus_high) |-> !gate_a_minus_low [*8]; endproperty
  a_dead_minus: assert property (p_dead_minus) else $error("minus leg no dead time");
  property p_blank; $rose(gate_a_plus_high) |-> gate_a_plus_high [*8]; endproperty
  a_blank: assert property (p_blank) else $error("on-time cut in blanking");
  property p_wait; psel && !penable |=> !pready ##1 pready; endproperty
  a_wait: assert property (p_wait) else $error("apb answer not in second access cycle");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_err_data; pready && pslverr && !pwrite |-> prdata == 32'h0000_0000; endproperty
  a_err_data: assert property (p_err_data) else $error("refused read data not zero");
endmodule // spcs_checker
bind spcs_top spcs_checker u_chk (.clk, .rst, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
  .gate_a_plus_high, .gate_a_plus_low, .gate_a_minus_high, .gate_a_minus_low);
`default_nettype wire

// ==== bench/spcs_winding.sv ====
// one motor winding behind a full bridge, current sensed against the dac target
// assumes the four leg gates and the target of one phase of spcs_top
`timescale 1ns/10ps
`default_nettype none
module spcs_winding (
  input wire logic clk,
  input wire logic plus_high,
  input wire logic plus_low,
  input wire logic minus_high,
  input wire logic minus_low,
  input wire logic [10:0] target,
  input wire logic sense_lost,
  output logic comp
);
  // signed, positive flows plus to minus
  logic signed [12:0] amps_q = 13'sh0000;
  logic [12:0] mag;
  always @(posedge clk) begin
    if (plus_high && minus_low)
      amps_q <= amps_q + 13'sh0001;
    else if (minus_high && plus_low)
      amps_q <= amps_q - 13'sh0001;
    else if (amps_q != 13'sh0000)
      amps_q <= amps_q - (amps_q > 0 ? 13'sh0001 : -13'sh0001);
  end
  assign mag = amps_q[12] ? 13'(-amps_q) : 13'(amps_q);
  // a short to ground bypasses the sensor, peak never seen
  assign comp = !sense_lost && mag >= {2'h0, target};
endmodule // spcs_winding
`default_nettype wire

// ==== design/spcs_pkg.sv ====
// constants, register map and types of the stepper phase current sequencer
// assumes a 200 MHz system clock and an APB master with 32-bit data
package spcs_pkg;

  // clock and timing
  localparam int CLK_MHZ = 200;
  localparam int PWM_BASE_NS = 36000;
  localparam int PWM_STEP_NS = 800;
  localparam int BLANK_NS = 1000;
  localparam int DEAD_NS = 100;
  localparam int PWM_BASE_CYC = PWM_BASE_NS * CLK_MHZ / 1000;
  localparam int PWM_STEP_CYC = PWM_STEP_NS * CLK_MHZ / 1000;
  localparam int BLANK_CYC = (BLANK_NS * CLK_MHZ + 999) / 1000;
  localparam int DEAD_CYC = (DEAD_NS * CLK_MHZ + 999) / 1000;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CURRENT = 8'h04;
  localparam logic [7:0] ADDR_PROFILE = 8'h08;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'h0C;
  localparam logic [7:0] ADDR_STEP_DELTA = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;

  // field positions
  localparam int CTRL_DECEL_HALT_POS = 0;
  localparam int CTRL_HALT_HOLD_POS = 1;
  localparam int CTRL_SHORT_POS = 2;
  localparam int CTRL_MS_POS = 4;
  localparam int CTRL_DIR_POS = 8;
  localparam int CUR_FS_POS = 0;
  localparam int CUR_OTL_POS = 8;
  localparam int CUR_PCODE_POS = 16;
  localparam int PROF_DECEL_POS = 0;
  localparam int PROF_INTERVAL_POS = 8;
  localparam int PROF_COUNT_HIGH_POS = 16;
  localparam int STAT_ANGLE_POS = 0;
  localparam int STAT_RUN_POS = 8;
  localparam int STAT_BUSY_POS = 9;
  localparam int STAT_WAIT_POS = 10;
  localparam int STAT_OC_POS = 12;

  // microstep modes in field order
  typedef enum logic [2:0] {
    MS_FULL_ONE, MS_FULL_TWO, MS_HALF_UNCOMP, MS_HALF_COMP,
    MS_QUARTER, MS_EIGHTH, MS_SIXTEENTH
  } spcs_mode_type;

  typedef enum logic [1:0] {PWM_ON, PWM_FAST, PWM_SLOW} spcs_pwm_type;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_WAIT, SEQ_RUN, SEQ_DECEL} spcs_seq_type;

  // reset values
  localparam spcs_mode_type MS_RESET = MS_HALF_COMP;
  localparam logic [5:0] HOME_ANGLE = 6'h08;
  localparam logic [5:0] HOME_ANGLE_FULL_ONE = 6'h00;
  localparam logic [4:0] FS_RESET = 5'h1F;
  localparam logic [4:0] PCODE_RESET = 5'h14;

  // leg states, one-hot so high and low can never be on together; full dac level and low ron boost limit
  localparam logic [1:0] LEG_OFF = 2'h0;
  localparam logic [1:0] LEG_LOW = 2'h1;
  localparam logic [1:0] LEG_HIGH = 2'h2;
  localparam logic [5:0] DAC_FULL = 6'h3F;
  localparam logic [4:0] FS_LOW_RON_MAX = 5'h02;

endpackage

// ==== design/spcs_top.sv ====
// stepper phase current sequencer: APB registers, step sequencer, phase table,
// peak-current PWM with blanking, mixed decay, on-time limit and dead time
// assumes synchronous comparator inputs and an external gate driver per leg
`timescale 1ns/10ps
`default_nettype none

module spcs_top
  import spcs_pkg::*;
#(
  parameter int PWM_BASE_CYCLES = spcs_pkg::PWM_BASE_CYC,
  parameter int PWM_STEP_CYCLES = spcs_pkg::PWM_STEP_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic comp_above_a,
  input wire logic comp_above_b,
  output logic gate_a_plus_high,
  output logic gate_a_plus_low,
  output logic gate_a_minus_high,
  output logic gate_a_minus_low,
  output logic gate_b_plus_high,
  output logic gate_b_plus_low,
  output logic gate_b_minus_high,
  output logic gate_b_minus_low,
  output logic [5:0] dac_level_a,
  output logic [5:0] dac_level_b,
  output logic phase_dir_neg_a,
  output logic phase_dir_neg_b,
  output logic [10:0] current_target_a,
  output logic [10:0] current_target_b,
  output logic low_side_ron_boost
);

  if (PWM_BASE_CYCLES <= BLANK_CYC + 1) begin : g_bad_base
    $error("pwm base period too short for blanking");
  end
  if (PWM_STEP_CYCLES < 0 || PWM_BASE_CYCLES + 31 * PWM_STEP_CYCLES > 65535) begin : g_bad_step
    $error("pwm period does not fit the period counter");
  end

  // quarter sine, 0..90 degrees in sixteenths of a full step
  function automatic logic [5:0] quarter_sine(input logic [4:0] k);
    case (k)
      5'h00: quarter_sine = 6'h00;
      5'h01: quarter_sine = 6'h06;
      5'h02: quarter_sine = 6'h0C;
      5'h03: quarter_sine = 6'h12;
      5'h04: quarter_sine = 6'h18;
      5'h05: quarter_sine = 6'h1E;
      5'h06: quarter_sine = 6'h23;
      5'h07: quarter_sine = 6'h28;
      5'h08: quarter_sine = 6'h2D;
      5'h09: quarter_sine = 6'h31;
      5'h0A: quarter_sine = 6'h34;
      5'h0B: quarter_sine = 6'h38;
      5'h0C: quarter_sine = 6'h3A;
      5'h0D: quarter_sine = 6'h3C;
      5'h0E: quarter_sine = 6'h3E;
      default: quarter_sine = 6'h3F;
    endcase
  endfunction

  // one table line for one phase: {direction negative, dac level}
  function automatic logic [6:0] phase_entry(input logic [5:0] ang);
    logic [4:0] k;
    k = (ang[4:0] > 5'h10) ? 5'(6'h20 - {1'b0, ang[4:0]}) : ang[4:0];
    phase_entry = {ang[5], quarter_sine(k)};
  endfunction

  function automatic logic [5:0] mode_step(input spcs_mode_type ms);
    case (ms)
      MS_FULL_ONE, MS_FULL_TWO: mode_step = 6'h10;
      MS_HALF_UNCOMP, MS_HALF_COMP: mode_step = 6'h08;
      MS_QUARTER: mode_step = 6'h04;
      MS_EIGHTH: mode_step = 6'h02;
      default: mode_step = 6'h01;
    endcase
  endfunction

  // limit in periods: 1 for code 1, then 8 per code up to 56
  function automatic logic [5:0] on_limit(input logic [4:0] v);
    if (v == 5'h01) begin
      on_limit = 6'h01;
    end else if (v >= 5'h08) begin
      on_limit = 6'h38;
    end else begin
      on_limit = {v[2:0] - 3'h1, 3'h0};
    end
  endfunction

  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == ADDR_CTRL) || (a == ADDR_CURRENT) || (a == ADDR_PROFILE) ||
                  (a == ADDR_COUNT_LOW) || (a == ADDR_STEP_DELTA) || (a == ADDR_STATUS);
  endfunction

  // apb: one wait state, request taken at the edge that sees pready high
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic access;
  logic done;
  logic wr_ok;
  assign access = psel & penable;
  assign done = access & pready_q;
  assign wr_ok = done & pwrite & addr_mapped(paddr);

  logic decel_halt_q;
  logic halt_hold_q;
  logic short_q;
  logic dir_q;
  spcs_mode_type ms_q;
  logic [4:0] fs_q;
  logic [4:0] otl_q;
  logic [4:0] pcode_q;
  logic [5:0] decel_q;
  logic [5:0] interval_q;
  logic [7:0] count_high_q;
  logic wr_launch;
  logic wr_delta;
  assign wr_launch = wr_ok & (paddr == ADDR_COUNT_LOW);
  assign wr_delta = wr_ok & (paddr == ADDR_STEP_DELTA);

  always_ff @(posedge clk) begin
    if (rst) begin
      decel_halt_q <= 1'b0;
      halt_hold_q <= 1'b0;
      short_q <= 1'b0;
      dir_q <= 1'b1;
      ms_q <= MS_RESET;
      fs_q <= FS_RESET;
      otl_q <= 5'h00;
      pcode_q <= PCODE_RESET;
      decel_q <= 6'h00;
      interval_q <= 6'h00;
      count_high_q <= 8'h00;
    end else if (ce && wr_ok) begin
      if (paddr == ADDR_CTRL) begin
        decel_halt_q <= pwdata[CTRL_DECEL_HALT_POS];
        halt_hold_q <= pwdata[CTRL_HALT_HOLD_POS];
        short_q <= pwdata[CTRL_SHORT_POS];
        ms_q <= spcs_mode_type'(pwdata[CTRL_MS_POS +: 3]);
        dir_q <= pwdata[CTRL_DIR_POS];
      end
      if (paddr == ADDR_CURRENT) begin
        fs_q <= pwdata[CUR_FS_POS +: 5];
        otl_q <= pwdata[CUR_OTL_POS +: 5];
        pcode_q <= pwdata[CUR_PCODE_POS +: 5];
      end
      if (paddr == ADDR_PROFILE) begin
        decel_q <= pwdata[PROF_DECEL_POS +: 6];
        interval_q <= pwdata[PROF_INTERVAL_POS +: 6];
        count_high_q <= pwdata[PROF_COUNT_HIGH_POS +: 8];
      end
    end
  end

  // base pwm period counter
  logic [15:0] period_cnt_q;
  logic [15:0] period_last;
  logic period_tick;
  assign period_last = 16'(PWM_BASE_CYCLES + PWM_STEP_CYCLES * int'(pcode_q) - 1);
  assign period_tick = (period_cnt_q >= period_last);

  always_ff @(posedge clk) begin
    if (rst) begin
      period_cnt_q <= 16'h0000;
    end else if (ce) begin
      period_cnt_q <= period_tick ? 16'h0000 : period_cnt_q + 16'h0001;
    end
  end

  // profile sequencer
  spcs_seq_type seq_q;
  logic [15:0] steps_left_q;
  logic [5:0] tick_cnt_q;
  logic run_flag_q;
  logic step_now;
  logic moving;
  assign moving = (seq_q == SEQ_RUN) || (seq_q == SEQ_DECEL);
  assign step_now = period_tick && (tick_cnt_q >= interval_q) && moving && !short_q && !halt_hold_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      tick_cnt_q <= 6'h00;
    end else if (ce && period_tick) begin
      tick_cnt_q <= (tick_cnt_q >= interval_q) ? 6'h00 : tick_cnt_q + 6'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      seq_q <= SEQ_IDLE;
      steps_left_q <= 16'h0000;
      run_flag_q <= 1'b0;
    end else if (ce) begin
      if (wr_launch) begin
        steps_left_q <= {count_high_q, pwdata[7:0]};
        if (decel_halt_q || halt_hold_q) begin
          seq_q <= SEQ_WAIT;
          run_flag_q <= 1'b0;
        end else begin
          seq_q <= SEQ_RUN;
          run_flag_q <= 1'b1;
        end
      end else begin
        case (seq_q)
          SEQ_IDLE: begin
            run_flag_q <= 1'b0;
          end
          SEQ_WAIT: begin
            if (!decel_halt_q && !halt_hold_q) begin
              seq_q <= SEQ_RUN;
              run_flag_q <= 1'b1;
            end
          end
          SEQ_RUN: begin
            if (halt_hold_q) begin
              seq_q <= SEQ_IDLE;
              run_flag_q <= 1'b0;
            end else if (decel_halt_q) begin
              seq_q <= SEQ_DECEL;
              if (steps_left_q > {10'h000, decel_q}) begin
                steps_left_q <= {10'h000, decel_q};
              end
            end else if (step_now && decel_q != 6'h00) begin
              steps_left_q <= steps_left_q - 16'h0001;
              if (steps_left_q <= 16'h0001) begin
                seq_q <= SEQ_IDLE;
                run_flag_q <= 1'b0;
              end
            end
            // zero deceleration: no countdown, runs until halted
          end
          SEQ_DECEL: begin
            if (halt_hold_q || steps_left_q == 16'h0000) begin
              seq_q <= SEQ_IDLE;
              run_flag_q <= 1'b0;
            end else if (step_now) begin
              steps_left_q <= steps_left_q - 16'h0001;
            end
          end
          default: begin
            seq_q <= SEQ_IDLE;
          end
        endcase
      end
    end
  end

  // step angle; six bits so sums and differences wrap at 64
  logic [5:0] angle_q;
  logic home_q;
  logic single_q;
  logic [5:0] angle_base;
  assign angle_base = home_q ? ((ms_q == MS_FULL_ONE) ? HOME_ANGLE_FULL_ONE : HOME_ANGLE) : angle_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      angle_q <= HOME_ANGLE;
      home_q <= 1'b1;
      single_q <= 1'b0;
    end else if (ce) begin
      if (wr_delta) begin
        angle_q <= angle_base + pwdata[5:0];
        home_q <= 1'b0;
        single_q <= 1'b1;
      end else if (step_now) begin
        angle_q <= dir_q ? angle_base + mode_step(ms_q) : angle_base - mode_step(ms_q);
        home_q <= 1'b0;
        single_q <= 1'b0;
      end else if (home_q) begin
        angle_q <= angle_base;
      end
    end
  end

  // phase table lookup, index 0 = phase A (cosine), 1 = phase B (sine)
  logic [6:0] entry [2];
  logic uncomp_diag;
  always_comb begin
    entry[0] = phase_entry(6'(angle_q + 6'h10));
    entry[1] = phase_entry(angle_q);
    // single-step moves never take the uncompensated override
    uncomp_diag = (ms_q == MS_HALF_UNCOMP) && !single_q && (angle_q[3:0] == 4'h8);
    if (uncomp_diag) begin
      entry[0][5:0] = DAC_FULL;
      entry[1][5:0] = DAC_FULL;
    end
  end

  logic [5:0] dac_q [2];
  logic dir_neg_q [2];
  logic [10:0] target_q [2];
  logic ron_boost_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int p = 0; p < 2; p++) begin
        dac_q[p] <= 6'h00;
        dir_neg_q[p] <= 1'b0;
        target_q[p] <= 11'h000;
      end
      ron_boost_q <= 1'b0;
    end else if (ce) begin
      for (int p = 0; p < 2; p++) begin
        dac_q[p] <= entry[p][5:0];
        dir_neg_q[p] <= entry[p][6];
        target_q[p] <= 11'(entry[p][5:0]) * 11'(fs_q);
      end
      ron_boost_q <= (fs_q <= FS_LOW_RON_MAX);
    end
  end

  // pwm per phase with blanking, mixed decay and on-time limit
  logic comp [2];
  assign comp[0] = comp_above_a;
  assign comp[1] = comp_above_b;
  spcs_pwm_type pwm_q [2];
  logic [15:0] blank_q [2];
  logic [5:0] on_cnt_q [2];
  logic [3:0] oc_q; // {b- high, b+ high, a- high, a+ high}
  logic fault [2];
  assign fault[0] = oc_q[0] | oc_q[1];
  assign fault[1] = oc_q[2] | oc_q[3];

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int p = 0; p < 2; p++) begin
        pwm_q[p] <= PWM_SLOW;
        blank_q[p] <= 16'h0000;
        on_cnt_q[p] <= 6'h00;
      end
    end else if (ce) begin
      for (int p = 0; p < 2; p++) begin
        if (period_tick) begin
          pwm_q[p] <= PWM_ON;
          blank_q[p] <= 16'(BLANK_CYC);
          on_cnt_q[p] <= (pwm_q[p] == PWM_ON && on_cnt_q[p] != 6'h3F) ? on_cnt_q[p] + 6'h01 : 6'h01;
        end else begin
          if (blank_q[p] != 16'h0000) begin
            blank_q[p] <= blank_q[p] - 16'h0001;
          end
          case (pwm_q[p])
            PWM_ON: if (blank_q[p] == 16'h0000 && comp[p]) pwm_q[p] <= PWM_FAST;
            PWM_FAST: if (!comp[p]) pwm_q[p] <= PWM_SLOW;
            PWM_SLOW: pwm_q[p] <= PWM_SLOW;
            default: pwm_q[p] <= PWM_SLOW;
          endcase
        end
      end
    end
  end

  // overcurrent flags; write one to clear, a new trip in the same cycle wins
  logic [3:0] oc_set;
  always_comb begin
    oc_set = 4'h0;
    for (int p = 0; p < 2; p++) begin
      if (period_tick && otl_q != 5'h00 && pwm_q[p] == PWM_ON && !fault[p] &&
          on_cnt_q[p] >= on_limit(otl_q)) begin
        oc_set[2 * p + (dir_neg_q[p] ? 1 : 0)] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      oc_q <= 4'h0;
    end else if (ce) begin
      if (wr_ok && paddr == ADDR_STATUS) begin
        oc_q <= (oc_q & ~pwdata[STAT_OC_POS +: 4]) | oc_set;
      end else begin
        oc_q <= oc_q | oc_set;
      end
    end
  end

  // leg requests, index 2p = plus terminal, 2p+1 = minus terminal
  logic [1:0] req [4];
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      if (short_q) begin
        req[2 * p] = LEG_LOW;
        req[2 * p + 1] = LEG_LOW;
      end else if (fault[p]) begin
        req[2 * p] = LEG_OFF;
        req[2 * p + 1] = LEG_OFF;
      end else begin
        case (pwm_q[p])
          PWM_ON: begin
            req[2 * p] = dir_neg_q[p] ? LEG_LOW : LEG_HIGH;
            req[2 * p + 1] = dir_neg_q[p] ? LEG_HIGH : LEG_LOW;
          end
          PWM_FAST: begin
            req[2 * p] = dir_neg_q[p] ? LEG_HIGH : LEG_LOW;
            req[2 * p + 1] = dir_neg_q[p] ? LEG_LOW : LEG_HIGH;
          end
          default: begin
            req[2 * p] = LEG_LOW;
            req[2 * p + 1] = LEG_LOW;
          end
        endcase
      end
    end
  end

  // dead time: a leg always passes through off before changing side
  logic [1:0] leg_q [4];
  logic [7:0] dead_q [4];
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        leg_q[i] <= LEG_OFF;
        dead_q[i] <= 8'h00;
      end
    end else if (ce) begin
      for (int i = 0; i < 4; i++) begin
        if (req[i] != leg_q[i] && leg_q[i] != LEG_OFF) begin
          leg_q[i] <= LEG_OFF;
          dead_q[i] <= 8'(DEAD_CYC);
        end else if (dead_q[i] != 8'h00) begin
          dead_q[i] <= dead_q[i] - 8'h01;
        end else begin
          leg_q[i] <= req[i];
        end
      end
    end
  end

  // apb answer, read data captured at the same edge that pready rises
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      ADDR_CTRL: begin
        rd_mux[CTRL_DECEL_HALT_POS] = decel_halt_q;
        rd_mux[CTRL_HALT_HOLD_POS] = halt_hold_q;
        rd_mux[CTRL_SHORT_POS] = short_q;
        rd_mux[CTRL_MS_POS +: 3] = ms_q;
        rd_mux[CTRL_DIR_POS] = dir_q;
      end
      ADDR_CURRENT: begin
        rd_mux[CUR_FS_POS +: 5] = fs_q;
        rd_mux[CUR_OTL_POS +: 5] = otl_q;
        rd_mux[CUR_PCODE_POS +: 5] = pcode_q;
      end
      ADDR_PROFILE: begin
        rd_mux[PROF_DECEL_POS +: 6] = decel_q;
        rd_mux[PROF_INTERVAL_POS +: 6] = interval_q;
        rd_mux[PROF_COUNT_HIGH_POS +: 8] = count_high_q;
      end
      ADDR_STATUS: begin
        rd_mux[STAT_ANGLE_POS +: 6] = angle_q;
        rd_mux[STAT_RUN_POS] = run_flag_q;
        rd_mux[STAT_BUSY_POS] = moving;
        rd_mux[STAT_WAIT_POS] = (seq_q == SEQ_WAIT);
        rd_mux[STAT_OC_POS +: 4] = oc_q;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (ce) begin
      pready_q <= access & ~pready_q;
      pslverr_q <= access & ~pready_q & ~addr_mapped(paddr);
      if (access && !pready_q && !pwrite) begin
        prdata_q <= rd_mux;
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign gate_a_plus_high = leg_q[0][1];
  assign gate_a_plus_low = leg_q[0][0];
  assign gate_a_minus_high = leg_q[1][1];
  assign gate_a_minus_low = leg_q[1][0];
  assign gate_b_plus_high = leg_q[2][1];
  assign gate_b_plus_low = leg_q[2][0];
  assign gate_b_minus_high = leg_q[3][1];
  assign gate_b_minus_low = leg_q[3][0];
  assign dac_level_a = dac_q[0];
  assign dac_level_b = dac_q[1];
  assign phase_dir_neg_a = dir_neg_q[0];
  assign phase_dir_neg_b = dir_neg_q[1];
  assign current_target_a = target_q[0];
  assign current_target_b = target_q[1];
  assign low_side_ron_boost = ron_boost_q;

endmodule // spcs_top

`default_nettype wire
